/* core/mbs_pkg.sv */
/*
 * Constants, types and the state structs of the multi-board sync GPIO port.
 * Assumes a single 250 MHz system clock with a synchronous active-high reset.
 */
package mbs_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int GPIO_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SYNC_N = 2;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] ADDR_OUT  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_OE   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_IN   = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_CMD  = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h14;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int CMD_SW     = 0;
	localparam int CMD_ARM    = 1;
	localparam int CMD_DISARM = 2;
	localparam int STAT_ARMED = 0;
	localparam int STAT_EXT   = 1;
	localparam int STAT_DRV   = 2;
	localparam int CTRL_W     = 11;
	localparam logic [GPIO_W-1:0] OUT_RST  = 8'h00;
	localparam logic [GPIO_W-1:0] OE_RST   = 8'h00;
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ        = 250;
	localparam int SYNC_PULSE_NS  = 100;
	localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W          = $clog2(SYNC_PULSE_CYC + 1);

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		SRC_OFF,
		SRC_EXT,
		SRC_SW,
		SRC_RSV
	} mbs_src_t;

	typedef enum logic [1:0] {
		TSRC_EXT,
		TSRC_SYNC1,
		TSRC_SYNC2,
		TSRC_RSV
	} mbs_tsrc_t;

	typedef struct packed {
		logic [SYNC_N-1:0] sync_en;
		logic              trig_inv;
		logic              trig_fall;
		logic              trig_en;
		mbs_tsrc_t         trig_src;
		mbs_src_t          out2_src;
		mbs_src_t          out1_src;
	} mbs_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} mbs_bus_req_t;

	typedef struct packed {
		logic [GPIO_W-1:0] out;
		logic [GPIO_W-1:0] oe;
	} mbs_pins_t;

	typedef struct packed {
		logic [GPIO_W-1:0]             sw_out;
		logic [GPIO_W-1:0]             sw_oe;
		mbs_ctrl_t                     ctrl;
		logic                          armed;
		logic                          frame_trig;
		logic                          sw_pulse;
		logic [SYNC_N-1:0][CNT_W-1:0]  cnt;
		mbs_pins_t                     pins;
		logic [DATA_W-1:0]             rd_data;
	} mbs_state_t;

endpackage

/* core/mbs_sync_edge.sv */
/*
 * Two-stage synchroniser with rise and fall detection, one per bit.
 * Assumes asynchronous pin levels; pulses are one clock wide.
 */
`timescale 1ns/100ps
`default_nettype none

module mbs_sync_edge #(
	parameter int W = 9
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] prev;
	} mbs_edge_state_t;

	mbs_edge_state_t s;
	mbs_edge_state_t next_s;

	always_comb begin
		next_s      = s;
		next_s.s1   = d_i;
		next_s.s2   = s.s1;
		next_s.prev = s.s2;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// per-bit edges, comparing the second stage with its one-clock-delayed copy
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign q_o[i]    = s.s2[i];
			assign rise_o[i] = s.s2[i] & ~s.prev[i];
			assign fall_o[i] = ~s.s2[i] & s.prev[i];
		end
	endgenerate

	chk_two_stage_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		rise_o[0] && !$past(rst_i, 3) |-> $past(d_i[0], 2) && !$past(d_i[0], 3))
		else $error("rise seen without two-stage delay");

endmodule

`default_nettype wire

/* core/mbs_gpio.sv */
/*
 * Multi-board sync GPIO port: eight two-way lines, lines 1 and 2 doubling
 * as inter-board trigger lines, with master forwarding and slave arming.
 * Assumes a register master on the same clock, pins that are asynchronous,
 * and pads that resolve each line from the output enables.
 */
// The register offsets and strobed register access were chosen for this implementation.
//
// Overview of operation
// - eight two-way general lines wire straight to the other boards.
// - software reads each line level and writes a level to drive.
// - lines one and two also serve as the two sync lines.
// - linked boards start acquisition on one or two shared trigger events.
// - master sync output comes from external trigger or software pulse.
// - one master drives the sync lines; all other boards only listen.
// - each sync output has its own independent source select.
// - source choices include disabled and qualified external frame trigger.
// - trigger qualification uses enable, edge and polarity, forwarded or not.
// - slave may take its trigger from sync line one or two.
// - armed slave waits idle until the selected sync line fires.
// - master trigger sends a start signal over the chosen sync line.
`timescale 1ns/100ps
`default_nettype none

module mbs_gpio
	import mbs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire mbs_bus_req_t      bus_i,
	output logic      [DATA_W-1:0] rd_data_o,
	input  wire logic [GPIO_W-1:0] gpio_in_i,
	output logic      [GPIO_W-1:0] gpio_out_o,
	output logic      [GPIO_W-1:0] gpio_oe_o,
	input  wire logic              ext_trig_i,
	output logic                   frame_trig_o,
	output logic                   armed_o
);

	localparam int PW = SYNC_PULSE_CYC;
	localparam logic [CNT_W-1:0] PULSE_LD = CNT_W'(SYNC_PULSE_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	mbs_state_t s;
	mbs_state_t next_s;

	logic [GPIO_W:0]   lvl;
	logic [GPIO_W:0]   rise;
	logic [GPIO_W:0]   fall;
	logic              ext_evt;
	logic [SYNC_N-1:0] sync_evt;
	logic              sel_evt;
	logic              own_evt;
	logic [SYNC_N-1:0] fwd;
	logic [SYNC_N-1:0] listen;
	mbs_src_t          src [SYNC_N];

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// all eight lines plus the trigger pin
	mbs_sync_edge #(
		.W (GPIO_W + 1)
	) i_mbs_sync_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.d_i    ({ext_trig_i, gpio_in_i}),
		.q_o    (lvl),
		.rise_o (rise),
		.fall_o (fall)
	);

	// ************************************************************
	// trigger qualification and source selection
	// ************************************************************
	always_comb begin
		src[0] = s.ctrl.out1_src;
		src[1] = s.ctrl.out2_src;
		ext_evt = s.ctrl.trig_en &
			((s.ctrl.trig_fall ^ s.ctrl.trig_inv) ? fall[GPIO_W] : rise[GPIO_W]);
		for (int k = 0; k < SYNC_N; k++) begin
			// edges of the re-timed sync lines
			sync_evt[k] = s.ctrl.trig_en &
				((s.ctrl.trig_fall ^ s.ctrl.trig_inv) ? fall[k] : rise[k]);
			fwd[k] = ((src[k] == SRC_EXT) & ext_evt) |
				((src[k] == SRC_SW) & s.sw_pulse);
		end
		listen[0] = (s.ctrl.trig_src == TSRC_SYNC1);
		listen[1] = (s.ctrl.trig_src == TSRC_SYNC2);
		case (s.ctrl.trig_src)
			TSRC_EXT:   sel_evt = ext_evt;
			TSRC_SYNC1: sel_evt = sync_evt[0];
			TSRC_SYNC2: sel_evt = sync_evt[1];
			default:    sel_evt = 1'b0;
		endcase
		// software pulse also starts a master fed from its own trigger pin
		own_evt = sel_evt | (s.sw_pulse & (s.ctrl.trig_src == TSRC_EXT));
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s            = s;
		next_s.frame_trig = 1'b0;
		next_s.sw_pulse   = 1'b0;
		next_s.rd_data    = '0;

		if (bus_i.we) begin
			case (bus_i.addr)
				ADDR_OUT:  next_s.sw_out = bus_i.wdata[GPIO_W-1:0];
				ADDR_OE:   next_s.sw_oe  = bus_i.wdata[GPIO_W-1:0];
				ADDR_CTRL: next_s.ctrl   = mbs_ctrl_t'(bus_i.wdata[CTRL_W-1:0]);
				ADDR_CMD:  next_s.sw_pulse = bus_i.wdata[CMD_SW];
				default:   next_s.sw_out = s.sw_out;
			endcase
		end

		// an armed board fires once on its selected event, then disarms
		if (s.armed && own_evt) begin
			next_s.frame_trig = 1'b1;
			next_s.armed      = 1'b0;
		end
		// an arm in the same cycle as a trigger re-arms, so none is lost
		if (bus_i.we && bus_i.addr == ADDR_CMD) begin
			if (bus_i.wdata[CMD_ARM]) begin
				next_s.armed = 1'b1;
			end else if (bus_i.wdata[CMD_DISARM]) begin
				next_s.armed = 1'b0;
			end
		end

		// stretched so a board on another clock cannot miss it
		for (int k = 0; k < SYNC_N; k++) begin
			if (fwd[k]) begin
				next_s.cnt[k] = PULSE_LD;
			end else if (s.cnt[k] != '0) begin
				next_s.cnt[k] = s.cnt[k] - CNT_ONE;
			end
		end

		next_s.pins.out = next_s.sw_out;
		next_s.pins.oe  = next_s.sw_oe;
		for (int k = 0; k < SYNC_N; k++) begin
			// sync role of lines one and two
			if (next_s.ctrl.sync_en[k]) begin
				next_s.pins.out[k] = (next_s.cnt[k] != '0);
				next_s.pins.oe[k] = (src[k] != SRC_OFF) & ~listen[k] &
					(next_s.ctrl.out1_src == src[0]) &
					(next_s.ctrl.out2_src == src[1]) &
					(next_s.ctrl.trig_src == s.ctrl.trig_src);
			end
		end

		if (bus_i.re) begin
			case (bus_i.addr)
				ADDR_OUT:  next_s.rd_data = DATA_W'(s.sw_out);
				ADDR_OE:   next_s.rd_data = DATA_W'(s.sw_oe);
				ADDR_IN:   next_s.rd_data = DATA_W'(lvl[GPIO_W-1:0]);
				ADDR_CTRL: next_s.rd_data = DATA_W'(s.ctrl);
				ADDR_STAT: begin
					next_s.rd_data[STAT_ARMED] = s.armed;
					next_s.rd_data[STAT_EXT]   = lvl[GPIO_W];
					next_s.rd_data[STAT_DRV]   = s.cnt[0] != '0;
					next_s.rd_data[STAT_DRV+1] = s.cnt[1] != '0;
				end
				default:   next_s.rd_data = '0;
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s        <= '0;
			s.sw_out <= OUT_RST;
			s.sw_oe  <= OE_RST;
			s.ctrl   <= mbs_ctrl_t'(CTRL_RST);
		end else begin
			s <= next_s;
		end
	end

	assign rd_data_o    = s.rd_data;
	assign gpio_out_o   = s.pins.out;
	assign gpio_oe_o    = s.pins.oe;
	assign frame_trig_o = s.frame_trig;
	assign armed_o      = s.armed;

	// ************************************************************
	// check helpers
	// ************************************************************
	// age of the last load on line one, held once the pulse is over
	// so that the end check needs no long repetition
	localparam logic [CNT_W:0] AGE_END = (CNT_W + 1)'(PW + 1);
	localparam logic [CNT_W:0] AGE_ONE = (CNT_W + 1)'(1);

	logic [CNT_W:0] fwd0_age;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd0_age <= '0;
		end else if (fwd[0]) begin
			fwd0_age <= AGE_ONE;
		end else if (fwd0_age != '0 && fwd0_age != AGE_END) begin
			fwd0_age <= fwd0_age + AGE_ONE;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence rd_in_seq;
		bus_i.re && bus_i.addr == ADDR_IN;
	endsequence

	sequence arm_wait_seq;
		armed_o && !own_evt && !(bus_i.we && bus_i.addr == ADDR_CMD);
	endsequence

	sequence fwd0_seq;
		fwd[0] && s.ctrl.sync_en[0] && !(bus_i.we && bus_i.addr == ADDR_CTRL);
	endsequence

	chk_read_level: assert property (
		rd_in_seq |=> rd_data_o == DATA_W'($past(lvl[GPIO_W-1:0])))
		else $error("input level read back wrong");

	chk_write_drive: assert property (
		bus_i.we && bus_i.addr == ADDR_OUT |=>
			gpio_out_o[GPIO_W-1:SYNC_N] == $past(bus_i.wdata[GPIO_W-1:SYNC_N]))
		else $error("written level not driven");

	chk_listen_off: assert property (
		s.ctrl.sync_en[1] && listen[1] && !bus_i.we |=> !gpio_oe_o[1])
		else $error("listening sync line driven");

	chk_off_src: assert property (
		s.ctrl.sync_en[0] && s.ctrl.out1_src == SRC_OFF && !bus_i.we
			|=> !gpio_oe_o[0])
		else $error("disabled sync source still driving");

	chk_pulse_width: assert property (
		fwd0_seq |=> gpio_out_o[0] [*8])
		else $error("sync pulse too short");

	chk_pulse_end: assert property (
		s.ctrl.sync_en[0] && fwd0_age == AGE_END |-> !gpio_out_o[0])
		else $error("sync pulse not ended on time");

	chk_pulse_hold: assert property (
		s.ctrl.sync_en[0] && fwd0_age != '0 && fwd0_age != AGE_END
			|-> gpio_out_o[0])
		else $error("sync pulse dropped early");

	chk_arm_hold: assert property (
		arm_wait_seq |=> armed_o && !frame_trig_o)
		else $error("armed board left idle without trigger");

	chk_trig_fire: assert property (
		armed_o && own_evt && !(bus_i.we && bus_i.addr == ADDR_CMD)
			|=> frame_trig_o && !armed_o ##1 !frame_trig_o)
		else $error("selected trigger did not fire once");

	chk_idle_quiet: assert property (
		!armed_o |=> !frame_trig_o)
		else $error("trigger while not armed");

	chk_qual_off: assert property (
		!s.ctrl.trig_en |-> !ext_evt && sync_evt == '0)
		else $error("trigger seen while disabled");

	chk_arm_wins: assert property (
		bus_i.we && bus_i.addr == ADDR_CMD && bus_i.wdata[CMD_ARM] |=> armed_o)
		else $error("arm command not taken");

	chk_disarm_clear: assert property (
		bus_i.we && bus_i.addr == ADDR_CMD && !bus_i.wdata[CMD_ARM] &&
			bus_i.wdata[CMD_DISARM] |=> !armed_o)
		else $error("disarm command not taken");

	chk_read_idle: assert property (
		!bus_i.re |=> rd_data_o == '0)
		else $error("read data outside its cycle");

	chk_sw_forward: assert property (
		s.sw_pulse && s.ctrl.out1_src == SRC_SW && s.ctrl.sync_en[0] &&
			!(bus_i.we && bus_i.addr == ADDR_CTRL) |=> gpio_out_o[0])
		else $error("software pulse not forwarded");

endmodule

`default_nettype wire

/* sim/mbs_peer_board.sv */
/*
 * Behavioural peer board on the shared lines: it drives any line that the
 * bench asks for, and as sync master fires timed pulses on lines 1 and 2.
 * Assumes the bench resolves each line from both boards' enables.
 */
`timescale 1ns/100ps
`default_nettype none

module mbs_peer_board #(
	parameter int PULSE_CYC = 25
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] lvl_i,
	input  wire logic [1:0] fire_i,
	output logic      [7:0] oe_o,
	output logic      [7:0] out_o
);
	int         cnt [2];
	logic [7:0] lvl;

	// ************************************************************
	// line drivers
	// ************************************************************
	// drives whichever lines the bench enables, one clock later
	always @(posedge clk_i) begin
		if (rst_i) begin
			oe_o <= 8'h00;
			lvl <= 8'h00;
			cnt <= '{0, 0};
		end else begin
			oe_o <= oe_i;
			lvl <= lvl_i;
			for (int k = 0; k < 2; k++) begin
				if (fire_i[k])
					cnt[k] <= PULSE_CYC;
				else if (cnt[k] != 0)
					cnt[k] <= cnt[k] - 1;
			end
		end
	end

	assign out_o = lvl | {6'h00, cnt[1] != 0, cnt[0] != 0};
endmodule

`default_nettype wire

/* sim/test_mbs_gpio.sv */
/*
 * Self-checking bench of the sync GPIO port facing one peer board.
 * Assumes the package and core sources are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module test_mbs_gpio import mbs_pkg::*; ;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	mbs_bus_req_t      bus_i = '0;
	logic [DATA_W-1:0] rd_data_o;
	logic [GPIO_W-1:0] gpio_in_i;
	logic [GPIO_W-1:0] gpio_out_o;
	logic [GPIO_W-1:0] gpio_oe_o;
	logic              ext_trig_i = 1'b0;
	logic              frame_trig_o;
	logic              armed_o;
	logic [7:0]        p_oe_req = 8'h00;
	logic [7:0]        p_lvl = 8'h00;
	logic [1:0]        p_fire = 2'h0;
	logic [7:0]        p_oe;
	logic [7:0]        p_out;
	logic [7:0]        flt = 8'h00;
	logic [31:0]       d;
	int                errors = 0;
	int                cmp_count = 0;
	int                f, first, hi0, hi1;

	always #2 clk_i = ~clk_i;
	// undriven lines wander so a stale level never passes
	always @(posedge clk_i) flt <= ~flt;
	assign gpio_in_i = (gpio_oe_o & gpio_out_o) | (p_oe & p_out)
		| (~gpio_oe_o & ~p_oe & flt);

	mbs_gpio i_mbs_gpio (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
		.rd_data_o(rd_data_o), .gpio_in_i(gpio_in_i),
		.gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o),
		.ext_trig_i(ext_trig_i), .frame_trig_o(frame_trig_o),
		.armed_o(armed_o));
	mbs_peer_board #(.PULSE_CYC(SYNC_PULSE_CYC)) i_mbs_peer_board (
		.clk_i(clk_i), .rst_i(rst_i), .oe_i(p_oe_req), .lvl_i(p_lvl),
		.fire_i(p_fire), .oe_o(p_oe), .out_o(p_out));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus_i <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
		@(posedge clk_i);
		bus_i <= '0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		bus_i <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
		@(posedge clk_i);
		bus_i <= '0;
		@(negedge clk_i);
		v = rd_data_o;
		@(posedge clk_i);
	endtask

	task automatic watch(input int n);
		f = 0;
		first = 0;
		hi0 = 0;
		hi1 = 0;
		for (int i = 1; i <= n; i++) begin
			@(negedge clk_i);
			if (frame_trig_o === 1'b1) begin
				if (f == 0)
					first = i;
				f++;
			end
			if ((gpio_oe_o[0] & gpio_out_o[0]) === 1'b1)
				hi0++;
			if ((gpio_oe_o[1] & gpio_out_o[1]) === 1'b1)
				hi1++;
		end
		@(posedge clk_i);
	endtask

	// both boards driving one line at once
	always @(negedge clk_i) if (p_oe != 8'h00) chk(gpio_oe_o & p_oe, 0);

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		logic [7:0] adr [5] = '{ADDR_OUT, ADDR_OE, ADDR_CTRL, ADDR_CMD, 8'h20};
		chk(gpio_oe_o, 8'h00);
		chk(armed_o, 1'b0);
		foreach (adr[i]) begin
			rd(adr[i], d);
			chk(d, 32'h00000000);
		end
	endtask

	task automatic t_gpio();
		wr(ADDR_OE, 32'h000000FF);
		wr(ADDR_OUT, 32'h000000A5);
		chk(gpio_out_o, 8'hA5);
		chk(gpio_oe_o, 8'hFF);
		repeat (3) @(posedge clk_i);
		rd(ADDR_IN, d);
		chk(d, 32'h000000A5);
		wr(ADDR_OE, 32'h00000000);
		p_lvl <= 8'h3C;
		p_oe_req <= 8'hFF;
		repeat (4) @(posedge clk_i);
		rd(ADDR_IN, d);
		chk(d, 32'h0000003C);
		p_oe_req <= 8'h00;
		@(posedge clk_i);
	endtask

	task automatic t_edges();
		logic [10:0] cfg [4] = '{11'h241, 11'h2C1, 11'h341, 11'h3C1};
		logic        q;
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CTRL, 32'(cfg[c]));
			for (int e = 0; e < 2; e++) begin
				q = ((e == 0) == (cfg[c][8] == cfg[c][7]));
				wr(ADDR_CMD, 32'h00000002);
				chk(armed_o, 1'b1);
				ext_trig_i <= (e == 0);
				watch(32);
				chk(32'(f), 32'(q));
				chk(32'(hi0), q ? SYNC_PULSE_CYC : 0);
				if (q)
					chk(32'(first), 4);
			end
		end
	endtask

	task automatic t_sw();
		wr(ADDR_CTRL, 32'h00000646);
		wr(ADDR_CMD, 32'h00000001);
		watch(32);
		chk(32'(hi0), SYNC_PULSE_CYC);
		chk(32'(hi1), 0);
		ext_trig_i <= 1'b1;
		watch(32);
		chk(32'(hi1), SYNC_PULSE_CYC);
		chk(32'(hi0), 0);
		wr(ADDR_CTRL, 32'h00000600);
		wr(ADDR_CMD, 32'h00000001);
		watch(32);
		chk(32'(hi0), 0);
		chk(gpio_oe_o[1:0], 2'h0);
	endtask

	task automatic t_slave();
		logic [10:0] cfg [2] = '{11'h250, 11'h460};
		ext_trig_i <= 1'b0;
		p_lvl <= 8'h00;
		p_oe_req <= 8'h03;
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CTRL, 32'(cfg[k]));
			wr(ADDR_CMD, 32'h00000002);
			p_fire <= 2'(1 << (1 - k));
			@(posedge clk_i);
			p_fire <= 2'h0;
			watch(40);
			chk(32'(f), 0);
			chk(armed_o, 1'b1);
			p_fire <= 2'(1 << k);
			@(posedge clk_i);
			p_fire <= 2'h0;
			watch(40);
			chk(32'(f), 1);
			chk(armed_o, 1'b0);
			chk(gpio_oe_o[1:0], 2'h0);
		end
		p_oe_req <= 8'h00;
		@(posedge clk_i);
	endtask

	task automatic t_cmd();
		wr(ADDR_CTRL, 32'h00000070);
		wr(ADDR_CMD, 32'h00000003);
		watch(8);
		chk(32'(f), 0);
		rd(ADDR_STAT, d);
		chk(d, 32'h00000001);
		@(negedge clk_i);
		chk(rd_data_o, 32'h00000000);
		@(posedge clk_i);
		wr(ADDR_CMD, 32'h00000004);
		chk(armed_o, 1'b0);
		wr(ADDR_CMD, 32'h00000006);
		chk(armed_o, 1'b1);
		wr(ADDR_CMD, 32'h00000004);
		rd(ADDR_STAT, d);
		chk(d, 32'h00000000);
	endtask

	// ************************************************************
	// run control
	// ************************************************************
	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_gpio();
		t_edges();
		t_sw();
		t_slave();
		t_cmd();
		give_verdict();
	end

	// whole run is under two thousand cycles
	initial begin
		#80000;
		errors++;
		give_verdict();
	end
endmodule

`default_nettype wire
